// file: verilog/ecat_top.sv
// acquisition control with encoder compare, latching and result delivery
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
module ecat_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic hw_trig,
  input wire logic sync_in,
  output logic sync_out,
  input wire logic [8*24-1:0] adc_data,
  input wire logic [15:0] temp_data,
  input wire logic [7:0] short_det,
  input wire logic [7:0] break_det,
  output logic irq
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cmp;
    logic [31:0] dly;
    logic [31:0] dcnt;
    logic [ecat_pkg::NSTAT-1:0] stat;
    logic [ecat_pkg::NSTAT-1:0] mask;
    logic [31:0] cnt;
    logic [31:0] ncmp;
    logic [1:0] ab;
    logic eq;
    logic [31:0] ts;
    logic [31:0] arcnt;
    logic [31:0] lcnt;
    logic [31:0] lts;
    logic [15:0] ltmp;
    logic [8*24-1:0] lch;
    logic [15:0] flt;
    logic [ecat_pkg::QAW:0] lvl;
    logic [ecat_pkg::QAW-1:0] wp;
    logic [ecat_pkg::QAW-1:0] rp;
    logic sync;
    logic ap;
    logic aw;
    logic [7:0] aa;
    logic [31:0] rd;
    logic irq;
  } ecat_st_t;
  ecat_st_t s_q, s_d;
  // sequence queue: row = ts, count, temp, all eight channels
  logic [31:0] q_ts [ecat_pkg::QDEPTH];
  logic [31:0] q_cnt [ecat_pkg::QDEPTH];
  logic [15:0] q_tmp [ecat_pkg::QDEPTH];
  logic [8*24-1:0] q_ch [ecat_pkg::QDEPTH];
  logic step;
  logic dir;
  logic trig_cmp;
  logic acq;
  logic push;
  logic pop;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] wv;
  logic [31:0] rv;

  // quadrature decode
  always_comb begin
    logic x;
    logic y;
    x = s_q.ab[0] ^ enc_a;
    y = s_q.ab[1] ^ enc_b;
    dir = ~(enc_a ^ s_q.ab[1]);
    unique case (s_q.ctrl[ecat_pkg::C_EDGE +: 2])
      2'h0: step = x & enc_a & ~enc_b;
      2'h1: step = x;
      default: step = x | y;
    endcase
    if (x & y) begin
      step = 1'b0;
    end
  end

  // count reached compare; one pulse per match
  assign trig_cmp = s_q.ctrl[ecat_pkg::C_CMPEN] & (s_q.cnt == s_q.ncmp) & ~s_q.eq;

  always_comb begin
    logic t;
    t = 1'b0;
    unique case (s_q.ctrl[ecat_pkg::C_SRC +: 2])
      2'h0: t = 1'b1;
      2'h1: t = (s_q.dcnt == 32'h0000_0000);
      2'h2: t = hw_trig;
      default: t = sync_in | trig_cmp;
    endcase
    acq = s_q.ctrl[ecat_pkg::C_RUN] & t;
  end

  assign push = acq & s_q.ctrl[ecat_pkg::C_SEQ] & (s_q.lvl != (ecat_pkg::QAW+1)'(ecat_pkg::QDEPTH));
  assign wr_ok = s_q.ap & s_q.aw;
  assign rd_ok = hsel & hready & htrans[1] & ~hwrite;
  assign pop = rd_ok & (haddr[7:0] == ecat_pkg::A_POP) & (s_q.lvl != '0);
  assign wv = hwdata;

  always_comb begin
    rv = 32'h0000_0000;
    unique case (haddr[7:0])
      ecat_pkg::A_CTRL: rv = s_q.ctrl;
      ecat_pkg::A_CMP: rv = s_q.cmp;
      ecat_pkg::A_DELAY: rv = s_q.dly;
      ecat_pkg::A_STAT: rv = {28'h0, s_q.stat};
      ecat_pkg::A_MASK: rv = {28'h0, s_q.mask};
      ecat_pkg::A_CNT: rv = s_q.cnt;
      ecat_pkg::A_TS: rv = s_q.lts;
      ecat_pkg::A_ARCNT: rv = s_q.arcnt;
      ecat_pkg::A_LCNT: rv = s_q.lcnt;
      ecat_pkg::A_LTMP: rv = {16'h0, s_q.ltmp};
      ecat_pkg::A_QLVL: rv = {28'h0, s_q.lvl};
      ecat_pkg::A_POP: rv = (s_q.lvl != '0) ? q_cnt[s_q.rp] : 32'h0000_0000;
      ecat_pkg::A_FAULT: rv = {16'h0, s_q.flt};
      default: begin
        for (int i = 0; i < ecat_pkg::NCH; i++) begin
          if (haddr[7:0] == ecat_pkg::A_CH0 + 8'(4*i)) begin
            rv = {8'h0, s_q.lch[i*24 +: 24]};
          end
        end
      end
    endcase
  end

  always_comb begin
    logic [ecat_pkg::NSTAT-1:0] ev;
    logic [15:0] f;
    s_d = s_q;
    ev = '0;
    f = {break_det, short_det} & {16{s_q.ctrl[ecat_pkg::C_DIAG]}};
    s_d.ab = {enc_b, enc_a};
    s_d.ts = s_q.ts + 32'h0000_0001;
    if (step) begin
      s_d.cnt = dir ? s_q.cnt - 32'h0000_0001 : s_q.cnt + 32'h0000_0001;
    end
    s_d.eq = s_q.cnt == s_q.ncmp;
    s_d.sync = trig_cmp;
    if (trig_cmp & s_q.ctrl[ecat_pkg::C_MOD]) begin
      s_d.ncmp = s_q.ncmp + s_q.cmp;
    end
    if (s_q.ctrl[ecat_pkg::C_SRC +: 2] == 2'h1) begin
      s_d.dcnt = (s_q.dcnt == 32'h0000_0000) ? s_q.dly : s_q.dcnt - 32'h0000_0001;
    end
    ev[ecat_pkg::S_TRIG] = trig_cmp;
    ev[ecat_pkg::S_FLT] = |(f & ~s_q.flt);
    s_d.flt = s_q.flt | f;
    if (acq) begin
      ev[ecat_pkg::S_ACQ] = 1'b1;
      s_d.lcnt = s_q.cnt;
      s_d.lts = s_q.ts;
      s_d.ltmp = temp_data;
      for (int i = 0; i < ecat_pkg::NCH; i++) begin
        if (s_q.ctrl[ecat_pkg::C_AVG] & ~s_q.ctrl[ecat_pkg::C_SEQ]) begin
          s_d.lch[i*24 +: 24] = 24'((25'(s_q.lch[i*24 +: 24]) + 25'(adc_data[i*24 +: 24])) >> 1);
        end else begin
          s_d.lch[i*24 +: 24] = adc_data[i*24 +: 24];
        end
      end
      if (~s_q.ctrl[ecat_pkg::C_SEQ]) begin
        s_d.arcnt = s_q.arcnt + 32'h0000_0001;
      end else if (~push) begin
        ev[ecat_pkg::S_OVF] = 1'b1;
      end
    end
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.lvl = s_q.lvl + (ecat_pkg::QAW+1)'(push) - (ecat_pkg::QAW+1)'(pop);
    s_d.ap = hsel & hready & htrans[1];
    s_d.aw = hwrite;
    s_d.aa = haddr[7:0];
    if (rd_ok) begin
      s_d.rd = rv;
    end
    if (wr_ok) begin
      unique case (s_q.aa)
        ecat_pkg::A_CTRL: s_d.ctrl = wv;
        ecat_pkg::A_CMP: begin
          s_d.cmp = wv;
          s_d.ncmp = wv;
        end
        ecat_pkg::A_DELAY: s_d.dly = wv;
        ecat_pkg::A_STAT: s_d.stat = s_q.stat & ~wv[ecat_pkg::NSTAT-1:0];
        ecat_pkg::A_MASK: s_d.mask = wv[ecat_pkg::NSTAT-1:0];
        ecat_pkg::A_CNT: s_d.cnt = wv;
        ecat_pkg::A_FAULT: s_d.flt = (s_q.flt & ~wv[15:0]) | f;
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    s_d.stat = s_d.stat | ev;
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en & push) begin
      q_ts[s_q.wp] <= s_q.ts;
      q_cnt[s_q.wp] <= s_q.cnt;
      q_tmp[s_q.wp] <= temp_data;
      q_ch[s_q.wp] <= adc_data;
    end
  end

  assign hrdata = s_q.rd;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sync_out = s_q.sync;
  assign irq = s_q.irq;

  // checks
  sequence cmp_hit_s;
    clk_en & trig_cmp;
  endsequence
  sequence acq_hit_s;
    clk_en & acq;
  endsequence
  sequence pulse_gap_s;
    clk_en & trig_cmp ##1 clk_en;
  endsequence

  one_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    cmp_hit_s |=> !trig_cmp)
    else $error("compare fired twice");
  sync_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    pulse_gap_s |=> !sync_out)
    else $error("sync pulse too long");
  sync_out_a: assert property (@(posedge core_clk) disable iff (reset)
    cmp_hit_s |=> sync_out)
    else $error("sync output missed trigger");
  sync_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & ~trig_cmp |=> !sync_out)
    else $error("sync output without trigger");
  cmp_eq_a: assert property (@(posedge core_clk) disable iff (reset)
    trig_cmp |-> s_q.cnt == s_q.ncmp)
    else $error("compare fired off value");
  cmp_off_a: assert property (@(posedge core_clk) disable iff (reset)
    ~s_q.ctrl[ecat_pkg::C_CMPEN] |-> !trig_cmp)
    else $error("compare fired while disabled");
  trig_status_a: assert property (@(posedge core_clk) disable iff (reset)
    cmp_hit_s |=> s_q.stat[ecat_pkg::S_TRIG])
    else $error("compare status not set");
  modulo_step_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & trig_cmp & s_q.ctrl[ecat_pkg::C_MOD] & ~wr_ok |=> s_q.ncmp == $past(s_q.ncmp) + $past(s_q.cmp))
    else $error("modulo compare not advanced");
  no_mod_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & trig_cmp & ~s_q.ctrl[ecat_pkg::C_MOD] & ~wr_ok |=> s_q.ncmp == $past(s_q.ncmp))
    else $error("compare value moved without modulo");
  count_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & ~step & ~(wr_ok & (s_q.aa == ecat_pkg::A_CNT)) |=> s_q.cnt == $past(s_q.cnt))
    else $error("count moved without edge");
  count_move_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & step & ~(wr_ok & (s_q.aa == ecat_pkg::A_CNT)) |=>
    (s_q.cnt == $past(s_q.cnt) + 32'h0000_0001) || (s_q.cnt == $past(s_q.cnt) - 32'h0000_0001))
    else $error("count step not one");
  x1_edge_a: assert property (@(posedge core_clk) disable iff (reset)
    step & (s_q.ctrl[ecat_pkg::C_EDGE +: 2] == 2'h0) |-> enc_a & ~enc_b & ~s_q.ab[0])
    else $error("single edge mode counted wrong edge");
  step_mask_a: assert property (@(posedge core_clk) disable iff (reset)
    (enc_a ^ s_q.ab[0]) & (enc_b ^ s_q.ab[1]) |-> !step)
    else $error("count on double transition");
  time_step_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en |=> s_q.ts == $past(s_q.ts) + 32'h0000_0001)
    else $error("time base stalled");
  latch_ts_a: assert property (@(posedge core_clk) disable iff (reset)
    acq_hit_s |=> s_q.lts == $past(s_q.ts))
    else $error("time stamp not latched");
  latch_cnt_a: assert property (@(posedge core_clk) disable iff (reset)
    acq_hit_s |=> s_q.lcnt == $past(s_q.cnt))
    else $error("count not latched");
  latch_tmp_a: assert property (@(posedge core_clk) disable iff (reset)
    acq_hit_s |=> s_q.ltmp == $past(temp_data))
    else $error("temperature not latched");
  acq_status_a: assert property (@(posedge core_clk) disable iff (reset)
    acq_hit_s |=> s_q.stat[ecat_pkg::S_ACQ])
    else $error("acquisition status not set");
  for (genvar g = 0; g < ecat_pkg::NCH; g++) begin : g_chan
    latch_chan_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en & acq & ~s_q.ctrl[ecat_pkg::C_AVG] |=> s_q.lch[g*24 +: 24] == $past(adc_data[g*24 +: 24]))
      else $error("channel not latched");
    avg_chan_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en & acq & s_q.ctrl[ecat_pkg::C_AVG] & ~s_q.ctrl[ecat_pkg::C_SEQ] |=> s_q.lch[g*24 +: 24] ==
      24'((25'($past(s_q.lch[g*24 +: 24])) + 25'($past(adc_data[g*24 +: 24]))) >> 1))
      else $error("channel average wrong");
  end
  no_run_a: assert property (@(posedge core_clk) disable iff (reset)
    ~s_q.ctrl[ecat_pkg::C_RUN] |-> !acq)
    else $error("acquisition while stopped");
  free_run_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.ctrl[ecat_pkg::C_RUN] & (s_q.ctrl[ecat_pkg::C_SRC +: 2] == 2'h0) |-> acq)
    else $error("free run missed acquisition");
  hw_start_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.ctrl[ecat_pkg::C_RUN] & (s_q.ctrl[ecat_pkg::C_SRC +: 2] == 2'h2) & hw_trig |-> acq)
    else $error("hardware trigger ignored");
  arcnt_inc_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & acq & ~s_q.ctrl[ecat_pkg::C_SEQ] |=> s_q.arcnt == $past(s_q.arcnt) + 32'h0000_0001)
    else $error("refresh counter not advanced");
  arcnt_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & (~acq | s_q.ctrl[ecat_pkg::C_SEQ]) |=> s_q.arcnt == $past(s_q.arcnt))
    else $error("refresh counter moved");
  push_level_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & push & ~pop |=> s_q.lvl == $past(s_q.lvl) + 4'h1)
    else $error("queue level not raised");
  queue_ptr_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & push |=> s_q.wp == $past(s_q.wp) + 3'h1)
    else $error("write pointer not advanced");
  queue_lvl_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.lvl <= 4'h8)
    else $error("queue level out of range");
  pop_level_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & pop & ~push |=> s_q.lvl == $past(s_q.lvl) - 4'h1)
    else $error("queue level not lowered");
  pop_empty_a: assert property (@(posedge core_clk) disable iff (reset)
    (s_q.lvl == 4'h0) |-> !pop)
    else $error("pop from empty queue");
  full_block_a: assert property (@(posedge core_clk) disable iff (reset)
    (s_q.lvl == 4'h8) |-> !push)
    else $error("push into full queue");
  queue_ovf_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & acq & s_q.ctrl[ecat_pkg::C_SEQ] & s_q.lvl == 4'h8 |=> s_q.stat[ecat_pkg::S_OVF])
    else $error("overflow not flagged");
  fault_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & ~wr_ok |=> (s_q.flt & $past(s_q.flt)) == $past(s_q.flt))
    else $error("fault latch lost a bit");
  fault_set_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & s_q.ctrl[ecat_pkg::C_DIAG] |=> (s_q.flt & $past({break_det, short_det})) == $past({break_det, short_det}))
    else $error("fault not latched");
  write_ctrl_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en & wr_ok & (s_q.aa == ecat_pkg::A_CTRL) |=> s_q.ctrl == $past(hwdata))
    else $error("control write lost");
  irq_level_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en |=> irq == |(s_q.stat & s_q.mask))
    else $error("interrupt level wrong");
endmodule : ecat_top

// file: verilog/ecat_pkg.sv
// constants for the encoder compare acquisition trigger
package ecat_pkg;
  localparam int NCH = 8;
  localparam int CHW = 24;
  localparam int TMPW = 16;
  localparam int QDEPTH = 8;
  localparam int QAW = 3;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMP = 8'h04;
  localparam logic [7:0] A_DELAY = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_CNT = 8'h14;
  localparam logic [7:0] A_TS = 8'h18;
  localparam logic [7:0] A_ARCNT = 8'h1C;
  localparam logic [7:0] A_LCNT = 8'h20;
  localparam logic [7:0] A_LTMP = 8'h24;
  localparam logic [7:0] A_QLVL = 8'h28;
  localparam logic [7:0] A_POP = 8'h2C;
  localparam logic [7:0] A_FAULT = 8'h30;
  localparam logic [7:0] A_CH0 = 8'h40;
  // ctrl fields
  localparam int C_EDGE = 0;   // [1:0] 0:x1 1:x2 2:x4
  localparam int C_CMPEN = 2;
  localparam int C_MOD = 3;
  localparam int C_SEQ = 4;    // 0 auto-refresh, 1 sequence
  localparam int C_SRC = 5;    // [6:5] 0 free,1 delay,2 hw trig,3 sync or compare trig
  localparam int C_AVG = 7;
  localparam int C_RUN = 8;
  localparam int C_DIAG = 9;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int S_TRIG = 0;
  localparam int S_ACQ = 1;
  localparam int S_OVF = 2;
  localparam int S_FLT = 3;
  localparam int NSTAT = 4;
endpackage : ecat_pkg

// file: bench/ecat_enc_model.sv
// quadrature encoder source, one quarter period per step
`timescale 1ns/100ps
module ecat_enc_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic step,
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) ph_q <= 2'h0;
    else if (step) ph_q <= ph_q + 2'h1;
  end
  // phases 00,10,11,01 give forward motion
  assign enc_a = ph_q[0] ^ ph_q[1];
  assign enc_b = ph_q[1];
endmodule : ecat_enc_model

// file: bench/ecat_top_tb.sv
// self-checking bench for the acquisition trigger block
`timescale 1ns/100ps
module ecat_top_tb;
  logic core_clk = 1'b0, reset = 1'b1, hwrite = 1'b0, hsel = 1'b0, hw_trig = 1'b0, step = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, ts1;
  logic [1:0] htrans = 2'h0;
  logic [7:0] short_det = 8'h00;
  logic [191:0] adc_data;
  logic [15:0] temp_data = 16'h1234;
  logic hreadyout, hresp, sync_out, irq, enc_a, enc_b;
  int n_errors = 0, cmp_count = 0, n_sync = 0, n0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (sync_out === 1'b1) n_sync <= n_sync + 1;
  ecat_top ecat_top_inst (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enc_a(enc_a), .enc_b(enc_b), .hw_trig(hw_trig), .sync_in(1'b0),
    .sync_out(sync_out), .adc_data(adc_data), .temp_data(temp_data), .short_det(short_det),
    .break_det(8'h00), .irq(irq));
  ecat_enc_model ecat_enc_model_inst (.core_clk(core_clk), .reset(reset), .step(step), .enc_a(enc_a),
    .enc_b(enc_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsel <= 1'b1;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  task automatic mv(input int n);
    repeat (n) begin
      step <= 1'b1;
      @(posedge core_clk);
      step <= 1'b0;
      @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask : mv
  task automatic trig;
    hw_trig <= 1'b1;
    @(posedge core_clk);
    hw_trig <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : trig
  task automatic t_reset;
    rchk(ecat_pkg::A_CTRL, ecat_pkg::CTRL_RST);
    rchk(ecat_pkg::A_STAT, 32'h0);
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rchk(8'hFC, 32'h0);
    bus(1'b1, ecat_pkg::A_CNT, 32'hDEAD_BEEF);
    rchk(ecat_pkg::A_CNT, 32'hDEAD_BEEF);
  endtask : t_reset
  task automatic t_edges;
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, ecat_pkg::A_CTRL, 32'h100 | m);
      bus(1'b1, ecat_pkg::A_CNT, 32'h0);
      mv(4);
      rchk(ecat_pkg::A_CNT, 32'h1 << m);
    end
  endtask : t_edges
  task automatic t_cmp;
    bus(1'b1, ecat_pkg::A_CTRL, 32'h166);
    bus(1'b1, ecat_pkg::A_CNT, 32'h0);
    bus(1'b1, ecat_pkg::A_CMP, 32'h5);
    bus(1'b1, ecat_pkg::A_MASK, 32'h1);
    bus(1'b1, ecat_pkg::A_STAT, 32'hF);
    n0 = n_sync;
    mv(7);
    chk(n_sync - n0, 32'h1);
    rchk(ecat_pkg::A_LCNT, 32'h5);
    rchk(ecat_pkg::A_LTMP, 32'h1234);
    for (int i = 0; i < 8; i++) rchk(ecat_pkg::A_CH0 + 8'(4 * i), {8'h0, adc_data[24 * i +: 24]});
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, ecat_pkg::A_STAT, 32'hF);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, ecat_pkg::A_CTRL, 32'h16E);
    bus(1'b1, ecat_pkg::A_CNT, 32'h0);
    bus(1'b1, ecat_pkg::A_CMP, 32'h4);
    n0 = n_sync;
    mv(9);
    chk(n_sync - n0, 32'h2);
  endtask : t_cmp
  task automatic t_auto;
    bus(1'b1, ecat_pkg::A_CTRL, 32'h342);
    bus(1'b0, ecat_pkg::A_ARCNT, 32'h0);
    n0 = rd;
    bus(1'b1, ecat_pkg::A_CNT, 32'h3);
    trig;
    bus(1'b0, ecat_pkg::A_TS, 32'h0);
    ts1 = rd;
    bus(1'b1, ecat_pkg::A_CNT, 32'h9);
    trig;
    rchk(ecat_pkg::A_LCNT, 32'h9);
    rchk(ecat_pkg::A_ARCNT, n0 + 2);
    bus(1'b0, ecat_pkg::A_TS, 32'h0);
    chk({31'h0, rd !== ts1}, 32'h1);
    bus(1'b1, ecat_pkg::A_CTRL, 32'h3C2);
    adc_data[23:0] <= 24'h000020;
    trig;
    rchk(ecat_pkg::A_CH0, 32'h0052_8018);
    short_det <= 8'h04;
    repeat (4) @(posedge core_clk);
    rchk(ecat_pkg::A_FAULT, 32'h4);
  endtask : t_auto
  task automatic t_seq;
    bus(1'b1, ecat_pkg::A_CTRL, 32'h152);
    for (int i = 1; i < 4; i++) begin
      bus(1'b1, ecat_pkg::A_CNT, 32'h10 * i);
      trig;
    end
    rchk(ecat_pkg::A_QLVL, 32'h3);
    for (int i = 1; i < 4; i++) rchk(ecat_pkg::A_POP, 32'h10 * i);
    rchk(ecat_pkg::A_QLVL, 32'h0);
    repeat (9) trig;
    bus(1'b0, ecat_pkg::A_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
  endtask : t_seq
  task automatic test_done;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    for (int i = 0; i < 8; i++) adc_data[24 * i +: 24] = 24'hA50010 + 24'(i);
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_edges();
    t_cmp();
    t_auto();
    t_seq();
    test_done();
  end
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule : ecat_top_tb
